// *** shared/wakeup_irq_pkg.sv ***
package wakeup_irq_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_P1_WAKE = 8'hC0;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'hC8;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC9;
    localparam logic [7:0] IDX_STACK = 8'hDF;
    localparam logic [7:0] IDX_CMP_A = 8'hE0;
    localparam logic [7:0] IDX_CMP_B = 8'hE1;
    localparam logic [7:0] IDX_OSC_MODE = 8'hE2;
    // stack pointer and global enable layout
    localparam int GLOBAL_EN_BIT = 7;
    localparam int SP_W = 3;
    localparam logic [2:0] SP_RESET = 3'h7;
    // comparator mode register fields
    localparam int CMP_EN_BIT = 6;
    localparam int CMP_FLAG_BIT = 5;
    // oscillator mode register fields
    localparam int OSC_SLOW_BIT = 2;
    localparam int OSC_SLEEP_BIT = 3;
    localparam int OSC_GREEN_BIT = 4;
    // flag register bits not restored from the shadow buffer
    localparam int TOUT_STAT_BIT = 4;
    localparam int PDOWN_STAT_BIT = 5;
    // source numbering: bits 0..7 follow the enable register
    localparam int SRC_TIMER_A = 4;
    localparam int SRC_CMP_A = 8;
    localparam int SRC_CMP_B = 9;
    localparam int SRC_COUNT = 10;
    // vector address and reset values
    localparam int PC_W = 12;
    localparam logic [11:0] VECTOR_ADDR = 12'h008;
    localparam logic [7:0] REG8_RESET = 8'h00;
    // oscillator settling, counted in high-speed oscillator clocks
    localparam int SETTLE_OSC_CLOCKS = 2048;
    // ref_clk is the high-speed oscillator, so one cycle per clock
    localparam int SETTLE_CYCLES = SETTLE_OSC_CLOCKS * 1;
    localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_CYCLES - 1);

    // one-hot power states
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_GREEN = 4'h2,
        ST_SLEEP = 4'h4,
        ST_SETTLE = 4'h8
    } power_state_t;

    // accumulator and flag register travelling together
    typedef struct packed {
        logic [7:0] accumulator;
        logic [7:0] flags;
    } shadow_t;
endpackage

// *** verilog/wakeup_and_interrupt_ctrl.sv ***
`timescale 1ns/1ps
module wakeup_and_interrupt_ctrl
    import wakeup_irq_pkg::*;
#(
    parameter int PORT_PINS = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // avalon-mm register slave
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // request events from peripherals and edge logic
    input wire logic [SRC_COUNT-1:0] src_event_i,
    // port pins watched for wake
    input wire logic [PORT_PINS-1:0] port0_pins_i,
    input wire logic [PORT_PINS-1:0] port1_pins_i,
    // core sequencer
    input wire logic vec_ack_i,
    input wire logic svc_return_i,
    input wire logic save_i,
    input wire logic restore_i,
    input wire shadow_t save_data_i,
    output shadow_t restore_data_o,
    output logic vec_req_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_vector_o,
    output logic [SP_W-1:0] stack_level_o,
    // power control
    output logic core_halt_o,
    output logic hosc_enable_o,
    output logic slow_mode_o
);
    // the register map is fixed at eight pins per port
    if (PORT_PINS != 8) begin : g_bad_width
        $error("PORT_PINS must be 8");
    end

    power_state_t state_r; // power state
    logic [10:0] settle_r; // settle countdown
    logic [7:0] p1_wake_r; // port1 wake enables
    logic [7:0] enable_r; // shared enable register
    logic [SRC_COUNT-1:0] flag_r; // all request flags
    logic global_irq_enable_r; // global enable
    logic [SP_W-1:0] sp_r; // stack level
    logic [7:0] cmp_a_r; // other comparator a bits
    logic [7:0] cmp_b_r; // other comparator b bits
    logic cmp_a_en_r; // comparator a enable
    logic cmp_b_en_r; // comparator b enable
    logic [7:0] osc_r; // oscillator mode register
    shadow_t shadow_r; // one-level shadow buffer
    logic done_r; // bus answer phase
    logic [7:0] rd_byte; // read mux
    logic [7:0] idx; // register index
    logic wr_fire; // write takes effect
    logic [PORT_PINS-1:0] p0_s1_r, p0_s2_r, p0_s3_r, p0_stable_r;
    logic [PORT_PINS-1:0] p1_s1_r, p1_s2_r, p1_s3_r, p1_stable_r;
    logic [PORT_PINS-1:0] p0_chg, p1_chg; // agreed level changes
    logic port_wake; // any port0 change or enabled port1 change
    logic [SRC_COUNT-1:0] en_all; // enables for all sources
    logic take; // request accepted by core

    assign idx = avs_address_i[9:2];
    // write lands on the edge where waitrequest is low
    assign wr_fire = avs_write_i & done_r & avs_byteenable_i[0];
    // one wait cycle on every access
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~done_r;

    // bus answer phase toggles once per access
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (avs_read_i | avs_write_i) & ~done_r;
        end
    end

    // read mux; port1 wake register is write-only and reads zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_IRQ_FLAGS: rd_byte = flag_r[7:0];
            IDX_IRQ_ENABLE: rd_byte = enable_r;
            IDX_STACK: rd_byte = {global_irq_enable_r, 4'h0, sp_r};
            IDX_CMP_A: begin
                rd_byte = cmp_a_r;
                rd_byte[CMP_EN_BIT] = cmp_a_en_r;
                rd_byte[CMP_FLAG_BIT] = flag_r[SRC_CMP_A];
            end
            IDX_CMP_B: begin
                rd_byte = cmp_b_r;
                rd_byte[CMP_EN_BIT] = cmp_b_en_r;
                rd_byte[CMP_FLAG_BIT] = flag_r[SRC_CMP_B];
            end
            IDX_OSC_MODE: rd_byte = osc_r;
            default: rd_byte = 8'h00; // unmapped reads zero
        endcase
    end

    // read data captured in the wait cycle, held until next read
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i & ~done_r) begin
            avs_readdata_o <= {24'h00_0000, rd_byte};
        end
    end

    // plain configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            p1_wake_r <= REG8_RESET;
            enable_r <= REG8_RESET;
            cmp_a_r <= REG8_RESET;
            cmp_b_r <= REG8_RESET;
            cmp_a_en_r <= 1'b0;
            cmp_b_en_r <= 1'b0;
        end else if (wr_fire) begin
            case (idx)
                IDX_P1_WAKE: p1_wake_r <= avs_writedata_i[7:0];
                IDX_IRQ_ENABLE: enable_r <= avs_writedata_i[7:0];
                IDX_CMP_A: begin
                    cmp_a_r <= avs_writedata_i[7:0];
                    cmp_a_en_r <= avs_writedata_i[CMP_EN_BIT];
                end
                IDX_CMP_B: begin
                    cmp_b_r <= avs_writedata_i[7:0];
                    cmp_b_en_r <= avs_writedata_i[CMP_EN_BIT];
                end
                default: ; // other registers have their own process
            endcase
        end
    end

    // all ten enables in source order
    assign en_all = {cmp_b_en_r, cmp_a_en_r, enable_r};

    // request flags, one per source; event beats a software clear
    for (genvar i = 0; i < SRC_COUNT; i++) begin : g_flag
        logic wr_hit; // software writes this flag
        logic [7:0] wr_idx; // register holding this flag
        int wr_bit; // bit position in that register
        assign wr_idx = (i == SRC_CMP_A) ? IDX_CMP_A :
                        (i == SRC_CMP_B) ? IDX_CMP_B : IDX_IRQ_FLAGS;
        assign wr_bit = (i >= SRC_CMP_A) ? CMP_FLAG_BIT : i;
        assign wr_hit = wr_fire & (idx == wr_idx);
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                flag_r[i] <= 1'b0;
            end else if (src_event_i[i]) begin
                // set regardless of enable, held in every power state
                flag_r[i] <= 1'b1;
            end else if (wr_hit) begin
                flag_r[i] <= avs_writedata_i[wr_bit];
            end
        end
    end

    // pins are asynchronous: three flops, change counts when 2 and 3 agree
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            p0_s1_r <= '0;
            p0_s2_r <= '0;
            p0_s3_r <= '0;
            p1_s1_r <= '0;
            p1_s2_r <= '0;
            p1_s3_r <= '0;
        end else begin
            p0_s1_r <= port0_pins_i;
            p0_s2_r <= p0_s1_r;
            p0_s3_r <= p0_s2_r;
            p1_s1_r <= port1_pins_i;
            p1_s2_r <= p1_s1_r;
            p1_s3_r <= p1_s2_r;
        end
    end

    // stable level follows only agreed samples
    assign p0_chg = ~(p0_s2_r ^ p0_s3_r) & (p0_s3_r ^ p0_stable_r);
    assign p1_chg = ~(p1_s2_r ^ p1_s3_r) & (p1_s3_r ^ p1_stable_r);
    assign port_wake = (|p0_chg) | (|(p1_chg & p1_wake_r));

    // stable copy; reset loads zero as baseline, so a high pin after reset counts as a change
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            p0_stable_r <= '0;
            p1_stable_r <= '0;
        end else begin
            p0_stable_r <= p0_stable_r ^ p0_chg;
            p1_stable_r <= p1_stable_r ^ p1_chg;
        end
    end

    // power state machine
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= ST_RUN;
            settle_r <= 11'h000;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (osc_r[OSC_SLEEP_BIT]) begin
                        state_r <= ST_SLEEP;
                    end else if (osc_r[OSC_GREEN_BIT]) begin
                        state_r <= ST_GREEN;
                    end
                end
                ST_SLEEP: begin
                    // only a port change wakes; timers are stopped
                    if (port_wake) begin
                        state_r <= ST_SETTLE;
                        settle_r <= SETTLE_LAST;
                    end
                end
                ST_SETTLE: begin
                    if (settle_r == 11'h000) begin
                        state_r <= ST_RUN;
                    end else begin
                        settle_r <= settle_r - 11'h001;
                    end
                end
                ST_GREEN: begin
                    // clock keeps running, so straight back to run
                    if (port_wake | src_event_i[SRC_TIMER_A]) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // oscillator mode register; wake clears entry bits
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            osc_r <= REG8_RESET;
        end else if (state_r == ST_SETTLE && settle_r == 11'h000) begin
            osc_r[OSC_SLEEP_BIT] <= 1'b0;
            osc_r[OSC_SLOW_BIT] <= 1'b0;
        end else if (state_r == ST_GREEN && (port_wake | src_event_i[SRC_TIMER_A])) begin
            osc_r[OSC_GREEN_BIT] <= 1'b0;
        end else if (wr_fire && idx == IDX_OSC_MODE && state_r == ST_RUN) begin
            osc_r <= avs_writedata_i[7:0];
        end
    end

    assign core_halt_o = (state_r != ST_RUN);
    assign hosc_enable_o = (state_r != ST_SLEEP);
    assign slow_mode_o = osc_r[OSC_SLOW_BIT];

    // vector request: global enable and an enabled pending flag, in run state only
    assign vec_req_o = global_irq_enable_r & (|(flag_r & en_all))
        & (state_r == ST_RUN);
    assign take = vec_ack_i & vec_req_o;

    // global enable and stack level; core events win over software
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            global_irq_enable_r <= 1'b0;
            sp_r <= SP_RESET;
        end else if (take) begin
            global_irq_enable_r <= 1'b0;
            sp_r <= sp_r + 3'h1;
        end else if (svc_return_i) begin
            global_irq_enable_r <= 1'b1;
            sp_r <= sp_r - 3'h1;
        end else if (wr_fire && idx == IDX_STACK) begin
            global_irq_enable_r <= avs_writedata_i[GLOBAL_EN_BIT];
            sp_r <= avs_writedata_i[SP_W-1:0];
        end
    end

    // vector load pulse to the program counter
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_load_o <= 1'b0;
            pc_vector_o <= '0;
        end else begin
            pc_load_o <= take;
            pc_vector_o <= VECTOR_ADDR;
        end
    end

    assign stack_level_o = sp_r;

    // shadow buffer; status bits stay live and are never restored
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shadow_r <= '0;
            restore_data_o <= '0;
        end else begin
            if (save_i) begin
                shadow_r <= save_data_i;
            end
            if (restore_i) begin
                restore_data_o <= shadow_r;
                restore_data_o.flags[TOUT_STAT_BIT] <= save_data_i.flags[TOUT_STAT_BIT];
                restore_data_o.flags[PDOWN_STAT_BIT] <= save_data_i.flags[PDOWN_STAT_BIT];
            end
        end
    end

    // helper: cycles spent in settle
    logic [11:0] settle_seen_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || state_r != ST_SETTLE) begin
            settle_seen_r <= 12'h000;
        end else begin
            settle_seen_r <= settle_seen_r + 12'h001;
        end
    end

    property p_sleep_wake;
        @(posedge ref_clk_i) disable iff (srst_i)
        (state_r == ST_SLEEP && port_wake) |=> (state_r == ST_SETTLE);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");

    property p_settle_len;
        @(posedge ref_clk_i) disable iff (srst_i)
        (state_r == ST_RUN && $past(state_r) == ST_SETTLE)
            |-> (settle_seen_r == 12'(SETTLE_CYCLES));
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

    property p_green_wake;
        @(posedge ref_clk_i) disable iff (srst_i)
        (state_r == ST_GREEN && src_event_i[SRC_TIMER_A])
            |=> (state_r == ST_RUN) && $stable(slow_mode_o);
    endproperty
    a_green_wake: assert property (p_green_wake) else $error("green wake wrong");

    property p_sleep_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        (state_r == ST_SLEEP && !port_wake) |=> (state_r == ST_SLEEP);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("spurious wake");

    property p_flag_set;
        @(posedge ref_clk_i) disable iff (srst_i)
        src_event_i[0] |=> flag_r[0] ##1 (flag_r[0] || $past(wr_fire));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_enter_service;
        @(posedge ref_clk_i) disable iff (srst_i)
        take |=> !global_irq_enable_r && pc_load_o && (sp_r == $past(sp_r) + 3'h1);
    endproperty
    a_enter_service: assert property (p_enter_service) else $error("entry wrong");

    property p_leave_service;
        @(posedge ref_clk_i) disable iff (srst_i)
        (svc_return_i && !take) |=> global_irq_enable_r;
    endproperty
    a_leave_service: assert property (p_leave_service) else $error("no re-enable");

    property p_vector_gate;
        @(posedge ref_clk_i) disable iff (srst_i)
        pc_load_o |-> $past(global_irq_enable_r) && !global_irq_enable_r;
    endproperty
    a_vector_gate: assert property (p_vector_gate) else $error("enable not set");
endmodule // wakeup_and_interrupt_ctrl

// *** test/core_seq_model.sv ***
`timescale 1ns/1ps
// behavioural core sequencer: takes the vector, runs a service, returns
module core_seq_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // controller side
    input wire logic vec_req_i,
    input wire logic pc_load_i,
    output logic vec_ack_o,
    output logic svc_return_o,
    // bench knobs: ack latency, service length
    input wire logic ack_en_i,
    input wire logic [3:0] ack_dly_i,
    input wire logic [7:0] svc_len_i
);
    logic [3:0] wait_r; // cycles the request has stood
    logic [8:0] svc_r; // service countdown, zero when idle

    // ack only a standing request, after the chosen latency
    always_ff @(posedge ref_clk_i) begin
        vec_ack_o <= 1'b0;
        if (srst_i || !vec_req_i || vec_ack_o) begin
            wait_r <= 4'h0;
        end else if (ack_en_i && wait_r >= ack_dly_i) begin
            vec_ack_o <= 1'b1;
        end else if (wait_r != 4'hF) begin
            wait_r <= wait_r + 4'h1; // saturate so a long stall never wraps
        end
    end

    // service body; the return pulse is the only way out of it
    always_ff @(posedge ref_clk_i) begin
        svc_return_o <= 1'b0;
        if (srst_i) begin
            svc_r <= 9'h000;
        end else if (pc_load_i) begin
            svc_r <= {1'b0, svc_len_i} + 9'h001;
        end else if (svc_r == 9'h001) begin
            svc_r <= 9'h000;
            svc_return_o <= 1'b1;
        end else if (svc_r != 9'h000) begin
            svc_r <= svc_r - 9'h001;
        end
    end
endmodule // core_seq_model

// *** test/tb_wakeup_and_interrupt_ctrl.sv ***
`timescale 1ns/1ps
module tb_wakeup_and_interrupt_ctrl import wakeup_irq_pkg::*; ();
    // clock, reset, register bus
    logic clk, srst, av_rd, av_wr, wait_req;
    logic [9:0] addr;
    logic [31:0] wdata, rdata;
    // sources, pins, core side
    logic [9:0] src;
    logic [7:0] p0, p1;
    logic vec_ack, svc_ret, save, restore, vec_req, pc_load, halt, hosc, slow;
    shadow_t save_d, restore_d;
    logic [11:0] pc_vec;
    logic [2:0] sl;
    // partner knobs
    logic ack_en;
    logic [3:0] ack_dly;
    logic [7:0] svc_len;
    int miscompares = 0;
    int checked = 0;

    wakeup_and_interrupt_ctrl #(.PORT_PINS(8)) wakeup_and_interrupt_ctrl_i (
        .ref_clk_i(clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .src_event_i(src),
        .port0_pins_i(p0), .port1_pins_i(p1), .vec_ack_i(vec_ack),
        .svc_return_i(svc_ret), .save_i(save), .restore_i(restore),
        .save_data_i(save_d), .restore_data_o(restore_d), .vec_req_o(vec_req),
        .pc_load_o(pc_load), .pc_vector_o(pc_vec), .stack_level_o(sl),
        .core_halt_o(halt), .hosc_enable_o(hosc), .slow_mode_o(slow));

    core_seq_model core_seq_model_i (
        .ref_clk_i(clk), .srst_i(srst), .vec_req_i(vec_req), .pc_load_i(pc_load),
        .vec_ack_o(vec_ack), .svc_return_o(svc_ret), .ack_en_i(ack_en),
        .ack_dly_i(ack_dly), .svc_len_i(svc_len));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        addr <= {idx, 2'b00};
        av_rd <= ~w;
        av_wr <= w;
        wdata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 40);
        q = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        check(32'(wait_req), 0);
        if (wait_req !== 1'b0) begin
            end_sim();
        end
        @(posedge clk); // gap so strobes never flip twice in one step
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask

    task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(idx, 1'b0, 8'h00, q);
        check(q, {24'h0, exp});
    endtask

    // one-cycle event, then one edge so the flag has settled
    task automatic pulse(input int k);
        src <= 10'(1 << k);
        @(posedge clk);
        src <= 10'h000;
        @(posedge clk);
    endtask

    // levels watched by wait_lvl, picked by number
    localparam int W_PC = 0;
    localparam int W_RET = 1;
    localparam int W_HALT = 2;
    localparam int W_HOSC = 3;
    function automatic logic lvl(input int sel);
        logic [3:0] lv;
        lv = {hosc, halt, svc_ret, pc_load};
        return lv[sel];
    endfunction

    // bounded wait for a level; running out ends the run
    task automatic wait_lvl(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (lvl(sel) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (lvl(sel) !== v) begin
            miscompares++;
            $display("[ERR] t=%0t wait seen=%h exp=%h", $time, lvl(sel), v);
            end_sim();
        end
    endtask

    // register holding a source's flag
    function automatic logic [7:0] sidx(input int k);
        return k < 8 ? IDX_IRQ_FLAGS : (k == 8 ? IDX_CMP_A : IDX_CMP_B);
    endfunction

    initial begin
        int n;
        int j;
        {srst, av_rd, av_wr, addr, wdata, src, p0, p1, save, restore} = '0;
        save_d = '0;
        {ack_en, ack_dly, svc_len} = '0;
        srst = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // reset values and access kinds
        check(32'(sl), 7);
        reg_chk(IDX_IRQ_FLAGS, 8'h00);
        reg_chk(IDX_IRQ_ENABLE, 8'h00);
        reg_chk(IDX_STACK, 8'h07);
        reg_chk(IDX_P1_WAKE, 8'h00);
        reg_wr(IDX_P1_WAKE, 8'hFE);
        reg_chk(IDX_P1_WAKE, 8'h00);
        reg_chk(8'h10, 8'h00); // unmapped index reads zero
        $display("test reset done");
        // global enable gates the vector
        reg_wr(IDX_IRQ_ENABLE, 8'h01);
        pulse(0);
        check(32'(vec_req), 0);
        reg_wr(IDX_STACK, 8'h87);
        check(32'(vec_req), 1);
        reg_wr(IDX_IRQ_FLAGS, 8'h00);
        // every source: flag set regardless, vector only when enabled
        for (int k = 0; k < SRC_COUNT; k++) begin
            j = (k + 1) % SRC_COUNT;
            if (k < 8) begin
                reg_wr(IDX_IRQ_ENABLE, 8'h01 << k);
            end else begin
                reg_wr(sidx(k), 8'h40);
            end
            pulse(j);
            reg_chk(sidx(j), j < 8 ? 8'h01 << j : 8'h20);
            check(32'(vec_req), 0);
            pulse(k);
            check(32'(vec_req), 1);
            reg_wr(IDX_IRQ_FLAGS, 8'h00);
            reg_wr(IDX_IRQ_ENABLE, 8'h00);
            reg_wr(IDX_CMP_A, 8'h00);
            reg_wr(IDX_CMP_B, 8'h00);
        end
        $display("test sources done");
        // take with a slow core, service, return
        reg_wr(IDX_IRQ_ENABLE, 8'h10);
        ack_en <= 1'b1;
        ack_dly <= 4'h3;
        svc_len <= 8'd60;
        pulse(SRC_TIMER_A);
        wait_lvl(W_PC, 1'b1, 20, n);
        check(32'(pc_vec), 32'(VECTOR_ADDR));
        ack_en <= 1'b0;
        reg_chk(IDX_STACK, 8'h00);
        check(32'(sl), 0);
        reg_chk(IDX_IRQ_FLAGS, 8'h10);
        reg_wr(IDX_IRQ_FLAGS, 8'h00);
        reg_chk(IDX_STACK, 8'h00);
        wait_lvl(W_RET, 1'b1, 80, n);
        @(posedge clk);
        reg_chk(IDX_STACK, 8'h87);
        reg_wr(IDX_IRQ_ENABLE, 8'h00);
        $display("test service done");
        // shadow keeps live status bits
        save_d <= 16'hA5FF;
        save <= 1'b1;
        @(posedge clk);
        save <= 1'b0;
        save_d <= 16'h3C00;
        restore <= 1'b1;
        @(posedge clk);
        restore <= 1'b0;
        @(posedge clk);
        check({16'h0, restore_d}, 32'hA5CF);
        $display("test shadow done");
        // green from slow, timer wake, no settle
        reg_wr(IDX_OSC_MODE, 8'h14);
        wait_lvl(W_HALT, 1'b1, 5, n);
        check(32'(hosc), 1);
        pulse(SRC_TIMER_A);
        check(32'(halt), 0);
        check(32'(slow), 1);
        reg_chk(IDX_OSC_MODE, 8'h04);
        reg_wr(IDX_OSC_MODE, 8'h10);
        wait_lvl(W_HALT, 1'b1, 5, n);
        p0 <= 8'h08;
        wait_lvl(W_HALT, 1'b0, 8, n);
        check(32'(slow), 0);
        $display("test green done");
        // power down: only enabled pins wake, settle, latched ext request
        reg_wr(IDX_IRQ_FLAGS, 8'h00);
        reg_wr(IDX_P1_WAKE, 8'h01);
        reg_wr(IDX_IRQ_ENABLE, 8'h01);
        ack_en <= 1'b1;
        ack_dly <= 4'h0;
        svc_len <= 8'd10;
        reg_wr(IDX_OSC_MODE, 8'h0C);
        wait_lvl(W_HALT, 1'b1, 5, n);
        check(32'(hosc), 0);
        pulse(SRC_TIMER_A);
        p1 <= 8'h02;
        repeat (20) @(posedge clk);
        check(32'(halt), 1);
        check(32'(hosc), 0);
        p1 <= 8'h03;
        wait_lvl(W_HOSC, 1'b1, 10, n);
        pulse(0);
        wait_lvl(W_HALT, 1'b0, 2100, n);
        check(n + 2, SETTLE_CYCLES);
        wait_lvl(W_PC, 1'b1, 10, n);
        ack_en <= 1'b0;
        check(32'(slow), 0);
        reg_chk(IDX_OSC_MODE, 8'h00);
        $display("test sleep done");
        end_sim();
    end
endmodule // tb_wakeup_and_interrupt_ctrl
